// *** inc/timer_pkg.sv ***
package timer_pkg;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bus_req_s;
    typedef enum logic [2:0] {
        SYNC_IDLE = 3'b001,
        SYNC_HIGH = 3'b010,
        SYNC_LOW = 3'b100
    } sync_e;
endpackage

// *** inc/timer_regs.svh ***
`ifndef TIMER_REGS_SVH
`define TIMER_REGS_SVH
// register byte offsets
`define ADDR_COUNT 8'h01
`define ADDR_INTCTL 8'h0b
`define ADDR_OPTION 8'h81
`define ADDR_IRQ_STATUS 8'hc0
`define ADDR_IRQ_CLEAR 8'hc1
`define ADDR_IRQ_ENABLE 8'hc2
// option register fields
`define OPT_SRC_BIT 5
`define OPT_EDGE_BIT 4
`define OPT_PSA_BIT 3
`define OPT_RATE_HI 2
`define OPT_RATE_LO 0
`define OPT_RESET 8'hff
// interrupt control fields
`define INTCTL_IE_BIT 5
`define INTCTL_IF_BIT 2
`define INTCTL_RESET 8'h00
// event status bit positions
`define EVT_OVF_BIT 0
`define EVT_WDT_BIT 1
`define EVT_WIDTH 2
// write inhibit length in instruction cycles
`define WR_INHIBIT 2'h2
// phase counter values for second and fourth phase clocks
`define PHASE_Q2 2'h1
`define PHASE_Q4 2'h3
`define PHASE_LAST 2'h3
`define COUNT_MAX 8'hff
`endif

// *** rtl/timer_counter.sv ***
// The strobed register port was decided locally.
`include "timer_regs.svh"
module timer_counter
    import timer_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // register port
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // core status
    input wire logic sleep,
    input wire logic wdt_clear,
    input wire logic wdt_tick,
    // external count pin
    input wire logic count_in,
    // watchdog side
    output logic wdt_prescaled,
    output logic wdt_clear_out,
    // interrupt
    output logic irq
);
    bus_req_s req;
    logic rst_meta_reg, rst_sync_reg;
    logic rstn;
    logic [1:0] phase_reg;
    logic [7:0] count_reg;
    logic [7:0] option_reg;
    logic [7:0] intctl_reg;
    logic [`EVT_WIDTH-1:0] status_reg;
    logic [`EVT_WIDTH-1:0] enable_reg;
    logic [1:0] inhibit_reg;
    logic [7:0] presc_reg;
    logic [7:0] presc_next;
    logic presc_out_reg;
    logic src_prev_reg;
    logic sel_prev_reg;
    logic pin_rise;
    logic samp_q2_reg;
    logic edge_pulse;
    logic presc_in;
    logic presc_tap;
    logic feed;
    logic tick;
    logic wr_count;
    logic ovf_evt;
    logic use_psa_tmr;
    logic sel_in;

    assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
    assign rstn = rst_sync_reg;

    // tap selection for the shared prescaler, returns one bit of the divider, or a constant one for watchdog code zero
    function automatic logic rate_tap(input logic [7:0] cnt, input logic [2:0] code,
                                      input logic to_tmr);
        logic [3:0] idx;
        idx = {1'b0, code} + (to_tmr ? 4'h0 : 4'h0);
        rate_tap = to_tmr ? cnt[idx[2:0]] : (code == 3'h0 ? 1'b1 : cnt[idx[2:0] - 3'h1]);
    endfunction

    // reset release through two flops
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // four phase clocks per instruction cycle
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            phase_reg <= 2'h0;
        else
            phase_reg <= phase_reg + 2'h1;
    end

    assign tick = (phase_reg == `PHASE_LAST);
    assign wr_count = req.wr && (req.addr == `ADDR_COUNT);
    assign use_psa_tmr = !option_reg[`OPT_PSA_BIT];
    assign sel_in = option_reg[`OPT_EDGE_BIT] ? !count_in : count_in;

    // option register, all ones on every reset
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            option_reg <= `OPT_RESET;
        else if (req.wr && req.addr == `ADDR_OPTION)
            option_reg <= req.wdata;
    end

    // raw selected-edge history; reset value matches the pin idle level under default option
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            sel_prev_reg <= 1'b1;
        else
            sel_prev_reg <= sel_in;
    end

    // prescaler sits ahead of sync, so it must see raw pin edges, not its own synced output
    assign pin_rise = sel_in && !sel_prev_reg;

    // prescaler input: input edges or cycles when routed to counter, watchdog ticks otherwise
    assign presc_in = use_psa_tmr ?
        (option_reg[`OPT_SRC_BIT] ? pin_rise : tick) : wdt_tick;

    // the divider itself is never mapped onto the bus
    always_comb
    begin
        presc_next = presc_reg;
        if ((wr_count && use_psa_tmr) || (wdt_clear && !use_psa_tmr))
            presc_next = 8'h00;
        else if (presc_in && !sleep)
            presc_next = presc_reg + 8'h01;
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            presc_reg <= 8'h00;
        else
            presc_reg <= presc_next;
    end

    assign presc_tap = rate_tap(presc_reg, option_reg[`OPT_RATE_HI:`OPT_RATE_LO],
                                use_psa_tmr);

    // prescaler output level; bypassed input when unassigned
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            presc_out_reg <= 1'b0;
        else if (use_psa_tmr && option_reg[`OPT_SRC_BIT])
            presc_out_reg <= presc_tap;
        else
            presc_out_reg <= sel_in;
    end

    // sample on the second phase, shift into history on the fourth, so levels shorter than four mclk periods can be missed
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            samp_q2_reg <= 1'b0;
            src_prev_reg <= 1'b0;
        end
        else
        begin
            if (phase_reg == `PHASE_Q2)
                samp_q2_reg <= presc_out_reg;
            if (phase_reg == `PHASE_Q4)
                src_prev_reg <= samp_q2_reg;
        end
    end

    // rising sync edge of the selected polarity, one pulse per instruction cycle
    assign edge_pulse = (phase_reg == `PHASE_Q4) && samp_q2_reg && !src_prev_reg;

    // what feeds the counter
    always_comb
    begin
        if (!option_reg[`OPT_SRC_BIT])
            feed = use_psa_tmr ? (tick && presc_tap && !presc_reg[0]) : tick;
        else if (use_psa_tmr)
            feed = edge_pulse;
        else
            feed = edge_pulse;
        if (option_reg[`OPT_SRC_BIT] == 1'b0 && use_psa_tmr)
            feed = tick && (presc_next != presc_reg) && rate_tap(presc_next,
                   option_reg[`OPT_RATE_HI:`OPT_RATE_LO], 1'b1) &&
                   !presc_tap;
        if (option_reg[`OPT_SRC_BIT] && use_psa_tmr)
            feed = edge_pulse;
    end

    // write inhibit counts instruction cycles after a counter write
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            inhibit_reg <= 2'h0;
        else if (wr_count)
            inhibit_reg <= `WR_INHIBIT;
        else if (tick && inhibit_reg != 2'h0)
            inhibit_reg <= inhibit_reg - 2'h1;
    end

    assign ovf_evt = feed && !sleep && !wr_count && inhibit_reg == 2'h0 &&
                     count_reg == `COUNT_MAX;

    // counter value cleared to zero by reset, so simulation starts known
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            count_reg <= 8'h00;
        else if (wr_count)
            count_reg <= req.wdata;
        else if (feed && !sleep && inhibit_reg == 2'h0)
            count_reg <= count_reg + 8'h01;
    end

    // interrupt control; flag set wins over software clear
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            intctl_reg <= `INTCTL_RESET;
        else
        begin
            if (req.wr && req.addr == `ADDR_INTCTL)
                intctl_reg <= req.wdata;
            if (ovf_evt)
                intctl_reg[`INTCTL_IF_BIT] <= 1'b1;
        end
    end

    // sticky event status, write-one-to-clear, set wins
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            status_reg <= '0;
        else
        begin
            for (int i = 0; i < `EVT_WIDTH; i++)
            begin
                if (req.wr && req.addr == `ADDR_IRQ_CLEAR && req.wdata[i])
                    status_reg[i] <= 1'b0;
            end
            if (ovf_evt)
                status_reg[`EVT_OVF_BIT] <= 1'b1;
            if (wdt_clear)
                status_reg[`EVT_WDT_BIT] <= 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            enable_reg <= '0;
        else if (req.wr && req.addr == `ADDR_IRQ_ENABLE)
            enable_reg <= req.wdata[`EVT_WIDTH-1:0];
    end

    // level interrupt, overflow source gated by the overflow enable bit too, watchdog source by its enable only
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            irq <= 1'b0;
        else
            irq <= |(status_reg & enable_reg & {1'b1, intctl_reg[`INTCTL_IE_BIT]});
    end

    // watchdog side outputs
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            wdt_prescaled <= 1'b0;
            wdt_clear_out <= 1'b0;
        end
        else
        begin
            // one pulse each time the low rate bits wrap, so code zero passes every tick
            wdt_prescaled <= use_psa_tmr ? wdt_tick : (wdt_tick &&
                ((presc_next & ((8'h01 << option_reg[`OPT_RATE_HI:`OPT_RATE_LO]) - 8'h01))
                == 8'h00));
            wdt_clear_out <= wdt_clear;
        end
    end

    // read data one cycle after strobe; unmapped reads zero
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            rdata <= 8'h00;
        else if (req.rd)
        begin
            case (req.addr)
                `ADDR_COUNT: rdata <= count_reg;
                `ADDR_INTCTL: rdata <= intctl_reg;
                `ADDR_OPTION: rdata <= option_reg;
                `ADDR_IRQ_STATUS: rdata <= {6'h00, status_reg};
                `ADDR_IRQ_ENABLE: rdata <= {6'h00, enable_reg};
                default: rdata <= 8'h00;
            endcase
        end
        else
            rdata <= 8'h00;
    end

    // write-inhibit check: no advance in the cycle after a counter write
    inhibit_hold_a: assert property (@(posedge mclk) disable iff (!rstn)
        wr_count ##1 !wr_count |=> $stable(count_reg))
        else $error("counter moved right after write");

    overflow_flag_a: assert property (@(posedge mclk) disable iff (!rstn)
        ovf_evt |=> intctl_reg[`INTCTL_IF_BIT])
        else $error("overflow did not set flag");

    sleep_stop_a: assert property (@(posedge mclk) disable iff (!rstn)
        sleep && !wr_count |=> $stable(count_reg))
        else $error("counter moved in sleep");

    presc_clear_a: assert property (@(posedge mclk) disable iff (!rstn)
        wr_count && use_psa_tmr |=> presc_reg == 8'h00)
        else $error("prescaler not cleared by write");

    wdt_clear_a: assert property (@(posedge mclk) disable iff (!rstn)
        wdt_clear && !use_psa_tmr |=> presc_reg == 8'h00)
        else $error("prescaler not cleared by watchdog clear");

    irq_mask_a: assert property (@(posedge mclk) disable iff (!rstn)
        !intctl_reg[`INTCTL_IE_BIT] && !(status_reg[`EVT_WDT_BIT] && enable_reg[`EVT_WDT_BIT])
        |=> !irq)
        else $error("masked interrupt raised");

    timer_step_a: assert property (@(posedge mclk) disable iff (!rstn)
        tick && !option_reg[`OPT_SRC_BIT] && !use_psa_tmr && !sleep && !wr_count &&
        inhibit_reg == 2'h0 |=> count_reg == $past(count_reg) + 8'h01)
        else $error("timer mode did not step");

    sample_phase_a: assert property (@(posedge mclk) disable iff (!rstn)
        phase_reg != `PHASE_Q2 |=> $stable(samp_q2_reg))
        else $error("sample taken off phase");

    option_reset_a: assert property (@(posedge mclk)
        $rose(rstn) |-> option_reg == `OPT_RESET)
        else $error("option not all ones after reset");

    bypass_a: assert property (@(posedge mclk) disable iff (!rstn)
        !use_psa_tmr |=> presc_out_reg == $past(sel_in))
        else $error("bypass path broken");

    wdt_bypass_a: assert property (@(posedge mclk) disable iff (!rstn)
        use_psa_tmr |=> wdt_prescaled == $past(wdt_tick))
        else $error("watchdog tick not passed raw");

    irq_raise_a: assert property (@(posedge mclk) disable iff (!rstn)
        status_reg[`EVT_OVF_BIT] && enable_reg[`EVT_OVF_BIT] && intctl_reg[`INTCTL_IE_BIT]
        |=> irq)
        else $error("enabled overflow did not raise interrupt");

    rdata_idle_a: assert property (@(posedge mclk) disable iff (!rstn)
        !rd |=> rdata == 8'h00)
        else $error("read data outside read slot");
endmodule

// *** testbench/count_source.sv ***
// stand-in for the external pulse source on the count pin
module count_source (
    // clock
    input wire logic mclk,
    // request: flip the line this many times
    input wire logic go,
    input wire logic [3:0] toggles,
    // pin and status
    output logic count_in,
    output logic busy
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HOLD = 6;
    logic [3:0] left;
    int hold_cnt;
    // pin starts low, as after power-up
    initial
    begin
        count_in = 1'b0;
        busy = 1'b0;
        left = 4'h0;
        hold_cnt = 0;
    end
    // each level held six mclk, safely above the four-cycle minimum
    always @(posedge mclk)
    begin
        if (go && !busy)
        begin
            left <= toggles;
            busy <= (toggles != 4'h0);
            hold_cnt <= HOLD;
        end
        else if (busy)
        begin
            if (hold_cnt > 1)
                hold_cnt <= hold_cnt - 1;
            else
            begin
                count_in <= !count_in;
                hold_cnt <= HOLD;
                left <= left - 4'h1;
                busy <= (left != 4'h1);
            end
        end
    end
endmodule

// *** testbench/testbench.sv ***
`include "timer_regs.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic sleep = 1'b0;
    logic wdt_clear = 1'b0;
    logic wdt_tick = 1'b0;
    logic go = 1'b0;
    logic [3:0] toggles = 4'h0;
    logic [7:0] rdata;
    logic count_in, busy, wdt_prescaled, wdt_clear_out, irq;
    logic rd_seen = 1'b0;
    logic [15:0] exp_q[$];
    logic [7:0] lo, hi;
    logic [31:0] seed = 32'h039148d9;
    int error_cnt = 0;
    int checked = 0;
    int wdt_pulses = 0;

    always #5 mclk = ~mclk;

    timer_counter i_dut (.mclk(mclk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .sleep(sleep), .wdt_clear(wdt_clear), .wdt_tick(wdt_tick),
        .count_in(count_in), .wdt_prescaled(wdt_prescaled), .wdt_clear_out(wdt_clear_out),
        .irq(irq));
    count_source i_src (.mclk(mclk), .go(go), .toggles(toggles), .count_in(count_in),
        .busy(busy));

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done;
        $display("mismatches %0d comparisons %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // read data stand only in the cycle after the strobe; a range absorbs phase slack
    always @(posedge mclk)
    begin
        if (rd_seen)
        begin
            {lo, hi} = exp_q.pop_front();
            chk(rdata, (rdata >= lo && rdata <= hi) ? rdata : lo);
        end
        rd_seen <= rd;
    end

    // watchdog pulses counted for the prescaler sharing checks
    always @(posedge mclk)
        if (wdt_prescaled === 1'b1)
            wdt_pulses++;

    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    task automatic rreg(input logic [7:0] a, input logic [7:0] l, input logic [7:0] h);
        exp_q.push_back({l, h});
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
    endtask

    task automatic flip_pin(input logic [3:0] n);
        int i;
        @(posedge mclk);
        toggles <= n;
        go <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
        for (i = 0; i < 300; i++)
        begin
            @(posedge mclk);
            if (!busy)
                break;
        end
        if (i == 300)
        begin
            error_cnt++;
            test_done();
        end
        repeat (12) @(posedge mclk);
    endtask

    task automatic ticks(input int n);
        repeat (n)
        begin
            @(posedge mclk);
            wdt_tick <= 1'b1;
            @(posedge mclk);
            wdt_tick <= 1'b0;
            repeat (2) @(posedge mclk);
        end
    endtask

    initial
    begin
        repeat (6) @(posedge mclk);
        resetn <= 1'b1;
        repeat (3) @(posedge mclk);
        rreg(`ADDR_OPTION, 8'hff, 8'hff);
        rreg(`ADDR_INTCTL, 8'h00, 8'h00);
        rreg(8'h55, 8'h00, 8'h00);
        // asleep: a random value must stay put
        sleep <= 1'b1;
        seed = lfsr(seed);
        wreg(`ADDR_COUNT, seed[7:0]);
        repeat (40) @(posedge mclk);
        rreg(`ADDR_COUNT, seed[7:0], seed[7:0]);
        sleep <= 1'b0;
        // free-running timer with interrupt armed
        wreg(`ADDR_OPTION, 8'h08);
        wreg(`ADDR_IRQ_ENABLE, 8'h01);
        wreg(`ADDR_INTCTL, 8'h20);
        wreg(`ADDR_COUNT, 8'hfa);
        repeat (40) @(posedge mclk);
        rreg(`ADDR_COUNT, 8'h01, 8'h04);
        @(negedge mclk);
        chk({7'h00, irq}, 8'h01);
        rreg(`ADDR_INTCTL, 8'h24, 8'h24);
        rreg(`ADDR_IRQ_STATUS, 8'h01, 8'h01);
        wreg(`ADDR_INTCTL, 8'h04);
        repeat (2) @(negedge mclk);
        chk({7'h00, irq}, 8'h00);
        // service: flag cleared before the enable returns
        wreg(`ADDR_IRQ_CLEAR, 8'h01);
        wreg(`ADDR_INTCTL, 8'h20);
        repeat (2) @(negedge mclk);
        chk({7'h00, irq}, 8'h00);
        // a fresh write holds the value through the next tick
        wreg(`ADDR_COUNT, 8'hfe);
        repeat (2) @(posedge mclk);
        rreg(`ADDR_COUNT, 8'hfe, 8'hfe);
        // every rate code: four counts in 2^(n+3) mclk each
        for (int n = 0; n < 8; n++)
        begin
            wreg(`ADDR_OPTION, {5'h00, n[2:0]});
            wreg(`ADDR_COUNT, 8'h00);
            repeat (32 << n) @(posedge mclk);
            rreg(`ADDR_COUNT, 8'h02, 8'h04);
        end
        // pin starts low: five flips give three rises; the next five, from high, give three falls
        wreg(`ADDR_OPTION, 8'h28);
        wreg(`ADDR_COUNT, 8'h00);
        flip_pin(4'h5);
        rreg(`ADDR_COUNT, 8'h03, 8'h03);
        wreg(`ADDR_OPTION, 8'h38);
        wreg(`ADDR_COUNT, 8'h00);
        flip_pin(4'h5);
        rreg(`ADDR_COUNT, 8'h03, 8'h03);
        // prescaler halves the four rising edges
        wreg(`ADDR_OPTION, 8'h20);
        wreg(`ADDR_COUNT, 8'h00);
        flip_pin(4'h8);
        rreg(`ADDR_COUNT, 8'h02, 8'h02);
        // hand-over to the watchdog: clear counter, move, then clear watchdog
        wreg(`ADDR_COUNT, 8'h00);
        wreg(`ADDR_OPTION, 8'h0a);
        @(posedge mclk);
        wdt_clear <= 1'b1;
        @(posedge mclk);
        wdt_clear <= 1'b0;
        @(negedge mclk);
        chk({7'h00, wdt_clear_out}, 8'h01);
        wdt_pulses = 0;
        ticks(8);
        chk(wdt_pulses[7:0], 8'h02);
        wreg(`ADDR_OPTION, 8'h02);
        wdt_pulses = 0;
        ticks(8);
        chk(wdt_pulses[7:0], 8'h08);
        rreg(`ADDR_IRQ_STATUS, 8'h02, 8'h02);
        repeat (3) @(posedge mclk);
        test_done();
    end
endmodule
